/* File: rtl/pmd_pkg.sv */
// Purpose: Constants for the second transceiver's management register slice
// Assumes: 16-bit management registers, 8-bit switch port registers
// Notes: Offsets are management register numbers and switch register numbers
package pmd_pkg;
  // Management addressing
  localparam logic [4:0] PMD_XCVR_RSVD = 5'h01;
  localparam logic [4:0] PMD_XCVR_OWN = 5'h02;
  localparam logic [4:0] PMD_REG_ADV = 5'h04;
  localparam logic [4:0] PMD_REG_PARTNER = 5'h05;
  localparam logic [4:0] PMD_REG_DIAG = 5'h1d;
  localparam logic [4:0] PMD_REG_SPECIAL = 5'h1f;
  // Switch port registers of the second port
  localparam logic [7:0] PMD_SW_CTRL_DIAG = 8'h2a;
  localparam logic [7:0] PMD_SW_DIST_LOW = 8'h2b;
  localparam logic [7:0] PMD_SW_CTRL_ADV = 8'h2c;
  localparam logic [7:0] PMD_SW_STAT_PARTNER = 8'h2e;
  localparam logic [7:0] PMD_SW_STAT_WIRE = 8'h2f;
  // Field positions in the management registers
  localparam int PMD_ADV_LO = 5;
  localparam int PMD_PAUSE_BIT = 10;
  localparam int PMD_ADV_RSVD_BIT = 9;
  localparam int PMD_DIAG_START_BIT = 15;
  localparam int PMD_DIAG_RES_LO = 13;
  localparam int PMD_DIAG_SHORT_BIT = 12;
  localparam int PMD_POL_BIT = 5;
  localparam int PMD_XOVER_BIT = 4;
  localparam int PMD_FORCE_BIT = 3;
  localparam int PMD_PWR_BIT = 2;
  localparam int PMD_LOOP_BIT = 1;
  // Field positions in the switch registers
  localparam int PMD_SW_START_BIT = 4;
  localparam int PMD_SW_RES_LO = 5;
  localparam int PMD_SW_SHORT_BIT = 7;
  localparam int PMD_SW_XOVER_BIT = 7;
  localparam int PMD_SW_POL_BIT = 5;
  // Reset and fixed values
  localparam logic [4:0] PMD_ADV_RST = 5'h1f;
  localparam logic [4:0] PMD_SELECTOR = 5'h01;
  localparam logic PMD_PWR_DIS_RST = 1'b1;
  localparam logic [1:0] PMD_RES_NORMAL = 2'h0;
  localparam logic [8:0] PMD_DIST_RST = 9'h000;
endpackage : pmd_pkg

/* File: rtl/pmd_regs.sv */
// Purpose: Advertisement, partner ability, cable diagnostic and special control registers
// Assumes: One management request per cycle, inputs synchronous to clk_i
// Notes: Aliased fields share storage with the switch port registers
//
// Contract
// - First transceiver address is reserved, reads zero
// - Pause advertise bit 10, RW, reset 1
// - Bits 8-5 advertise abilities, RW, reset 1
// - Partner pause bit 10 read-only, mirrors status
// - Partner bits 8-5 read-only mirror status
// - Writing start launches diagnostic, self-clears on completion
// - Outcome field bits 14-13, reset normal
// - Bit 12 flags short under ten meters
// - Nine-bit fault distance from two switch registers
// - Polarity bit 5 and crossover bit 4
// - Bit 2 inverted power saving, reset 1
// - Bit 1 remote loopback at own transceiver
`timescale 1ns/1ps
`default_nettype none
module pmd_regs
  import pmd_pkg::*;
(
  input wire logic clk_i, // Core clock, 50 MHz
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic mgmt_req_i, // Management access request
  input wire logic mgmt_we_i, // 1 write, 0 read
  input wire logic [4:0] transceiver_select_i, // Transceiver address
  input wire logic [4:0] transceiver_reg_select_i, // Register address
  input wire logic [15:0] mgmt_wdata_i, // Write data
  output logic [15:0] mgmt_rdata_o, // Read data
  output logic mgmt_ack_o, // Access done pulse
  input wire logic sw_req_i, // Switch register access request
  input wire logic sw_we_i, // 1 write, 0 read
  input wire logic [7:0] sw_addr_i, // Switch register number
  input wire logic [7:0] sw_wdata_i, // Switch write data
  output logic [7:0] sw_rdata_o, // Switch read data
  input wire logic [4:0] partner_ability_i, // Partner pause, 100F, 100H, 10F, 10H
  input wire logic polarity_rev_i, // Receive polarity reversed
  input wire logic crossover_state_i, // 1 crossover, 0 straight
  input wire logic diag_done_i, // Diagnostic finished pulse
  input wire logic [1:0] diag_result_i, // Outcome at completion
  input wire logic near_short_flag_i, // Short under ten meters
  input wire logic [8:0] diag_distance_i, // Fault distance count
  output logic [4:0] adv_ability_o, // Pause, 100F, 100H, 10F, 10H advertised
  output logic diag_start_o, // Diagnostic running request
  output logic force_link_o, // Force link pass
  output logic pwr_save_dis_o, // 1 disables power saving
  output logic remote_loop_o // Remote loopback at own transceiver
);
  import pmd_pkg::*;

  function automatic logic mgmt_hit(input logic [4:0] reg_sel);
    mgmt_hit = mgmt_req_i && transceiver_select_i == PMD_XCVR_OWN && transceiver_reg_select_i == reg_sel;
  endfunction : mgmt_hit

  function automatic logic sw_hit(input logic [7:0] addr);
    sw_hit = sw_req_i && sw_addr_i == addr;
  endfunction : sw_hit

  logic adv_rsvd_q;
  logic spec_rsvd_q;
  logic [1:0] diag_result_q;
  logic diag_short_q;
  logic [8:0] diag_dist_q;
  logic mgmt_wr_adv;
  logic mgmt_wr_diag;
  logic mgmt_wr_spec;
  logic sw_wr_adv;
  logic sw_wr_diag;
  logic start_set;
  logic [15:0] rd_d;
  logic [7:0] sw_rd_d;

  assign mgmt_wr_adv = mgmt_we_i && mgmt_hit(PMD_REG_ADV);
  assign mgmt_wr_diag = mgmt_we_i && mgmt_hit(PMD_REG_DIAG);
  assign mgmt_wr_spec = mgmt_we_i && mgmt_hit(PMD_REG_SPECIAL);
  assign sw_wr_adv = sw_we_i && sw_hit(PMD_SW_CTRL_ADV);
  assign sw_wr_diag = sw_we_i && sw_hit(PMD_SW_CTRL_DIAG);
  assign start_set = (mgmt_wr_diag && mgmt_wdata_i[PMD_DIAG_START_BIT]) ||
                     (sw_wr_diag && sw_wdata_i[PMD_SW_START_BIT]);

  ////////////////////////////////////////////////////////////////////////////////
  // Advertisement storage, shared with switch register 44
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      adv_ability_o <= PMD_ADV_RST;
      adv_rsvd_q <= 1'b0;
    end else if (mgmt_wr_adv) begin
      adv_ability_o <= {mgmt_wdata_i[PMD_PAUSE_BIT], mgmt_wdata_i[PMD_ADV_LO +: 4]};
      adv_rsvd_q <= mgmt_wdata_i[PMD_ADV_RSVD_BIT];
    end else if (sw_wr_adv) begin
      adv_ability_o <= sw_wdata_i[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Special control storage, shared with switch register 42
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      force_link_o <= 1'b0;
      pwr_save_dis_o <= PMD_PWR_DIS_RST;
      remote_loop_o <= 1'b0;
      spec_rsvd_q <= 1'b0;
    end else if (mgmt_wr_spec) begin
      force_link_o <= mgmt_wdata_i[PMD_FORCE_BIT];
      pwr_save_dis_o <= mgmt_wdata_i[PMD_PWR_BIT];
      remote_loop_o <= mgmt_wdata_i[PMD_LOOP_BIT];
      spec_rsvd_q <= mgmt_wdata_i[0];
    end else if (sw_wr_diag) begin
      force_link_o <= sw_wdata_i[PMD_FORCE_BIT];
      pwr_save_dis_o <= sw_wdata_i[PMD_PWR_BIT];
      remote_loop_o <= sw_wdata_i[PMD_LOOP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Cable diagnostic start and captured results
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      diag_start_o <= 1'b0;
    end else if (start_set) begin
      diag_start_o <= 1'b1;
    end else if (diag_done_i) begin
      diag_start_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      diag_result_q <= PMD_RES_NORMAL;
      diag_short_q <= 1'b0;
      diag_dist_q <= PMD_DIST_RST;
    end else if (diag_done_i) begin
      diag_result_q <= diag_result_i;
      diag_short_q <= near_short_flag_i;
      diag_dist_q <= diag_distance_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Management read path
  always_comb begin
    rd_d = 16'h0000;
    if (mgmt_hit(PMD_REG_ADV)) begin
      rd_d[PMD_PAUSE_BIT] = adv_ability_o[4];
      rd_d[PMD_ADV_RSVD_BIT] = adv_rsvd_q;
      rd_d[PMD_ADV_LO +: 4] = adv_ability_o[3:0];
      rd_d[4:0] = PMD_SELECTOR;
    end else if (mgmt_hit(PMD_REG_PARTNER)) begin
      rd_d[PMD_PAUSE_BIT] = partner_ability_i[4];
      rd_d[PMD_ADV_LO +: 4] = partner_ability_i[3:0];
    end else if (mgmt_hit(PMD_REG_DIAG)) begin
      rd_d[PMD_DIAG_START_BIT] = diag_start_o;
      rd_d[PMD_DIAG_RES_LO +: 2] = diag_result_q;
      rd_d[PMD_DIAG_SHORT_BIT] = diag_short_q;
      rd_d[8:0] = diag_dist_q;
    end else if (mgmt_hit(PMD_REG_SPECIAL)) begin
      rd_d[PMD_POL_BIT] = polarity_rev_i;
      rd_d[PMD_XOVER_BIT] = crossover_state_i;
      rd_d[PMD_FORCE_BIT] = force_link_o;
      rd_d[PMD_PWR_BIT] = pwr_save_dis_o;
      rd_d[PMD_LOOP_BIT] = remote_loop_o;
      rd_d[0] = spec_rsvd_q;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mgmt_rdata_o <= 16'h0000;
      mgmt_ack_o <= 1'b0;
    end else begin
      mgmt_ack_o <= mgmt_req_i;
      if (mgmt_req_i && !mgmt_we_i) begin
        mgmt_rdata_o <= rd_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Switch register read path
  always_comb begin
    sw_rd_d = 8'h00;
    if (sw_hit(PMD_SW_CTRL_DIAG)) begin
      sw_rd_d = {diag_short_q, diag_result_q, diag_start_o, force_link_o, pwr_save_dis_o,
                 remote_loop_o, diag_dist_q[8]};
    end else if (sw_hit(PMD_SW_DIST_LOW)) begin
      sw_rd_d = diag_dist_q[7:0];
    end else if (sw_hit(PMD_SW_CTRL_ADV)) begin
      sw_rd_d[4:0] = adv_ability_o;
    end else if (sw_hit(PMD_SW_STAT_PARTNER)) begin
      sw_rd_d[4:0] = partner_ability_i;
      sw_rd_d[PMD_SW_XOVER_BIT] = crossover_state_i;
    end else if (sw_hit(PMD_SW_STAT_WIRE)) begin
      sw_rd_d[PMD_SW_POL_BIT] = polarity_rev_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sw_rdata_o <= 8'h00;
    end else if (sw_req_i && !sw_we_i) begin
      sw_rdata_o <= sw_rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_rsvd_xcvr;
    mgmt_req_i && !mgmt_we_i && transceiver_select_i == PMD_XCVR_RSVD |=> mgmt_rdata_o == 16'h0000;
  endproperty
  a_rsvd_xcvr: assert property (p_rsvd_xcvr) else $error("reserved transceiver read not zero");

  property p_pause_wr;
    mgmt_wr_adv |=> adv_ability_o[4] == $past(mgmt_wdata_i[PMD_PAUSE_BIT]);
  endproperty
  a_pause_wr: assert property (p_pause_wr) else $error("pause advertise not written");

  property p_adv_wr;
    mgmt_wr_adv |=> adv_ability_o[3:0] == $past(mgmt_wdata_i[8:5]);
  endproperty
  a_adv_wr: assert property (p_adv_wr) else $error("ability advertise not written");

  // Port terms spelled out so that every operand is a sampled value
  property p_partner_rd;
    mgmt_req_i && !mgmt_we_i && transceiver_select_i == PMD_XCVR_OWN &&
      transceiver_reg_select_i == PMD_REG_PARTNER |=>
      mgmt_rdata_o[10] == $past(partner_ability_i[4]) && mgmt_rdata_o[8:5] == $past(partner_ability_i[3:0]) &&
      mgmt_rdata_o[4:0] == 5'h00;
  endproperty
  a_partner_rd: assert property (p_partner_rd) else $error("partner ability read wrong");

  property p_start_clear;
    diag_done_i && !start_set |=> !diag_start_o;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit not self-cleared");

  property p_start_set;
    start_set |=> diag_start_o ##1 (diag_start_o || $past(diag_done_i));
  endproperty
  a_start_set: assert property (p_start_set) else $error("start bit lost");

  property p_result_cap;
    diag_done_i |=> diag_result_q == $past(diag_result_i) && diag_dist_q == $past(diag_distance_i);
  endproperty
  a_result_cap: assert property (p_result_cap) else $error("diagnostic result not captured");

  property p_spec_wr;
    mgmt_wr_spec |=> pwr_save_dis_o == $past(mgmt_wdata_i[2]) && remote_loop_o == $past(mgmt_wdata_i[1]) &&
      force_link_o == $past(mgmt_wdata_i[3]);
  endproperty
  a_spec_wr: assert property (p_spec_wr) else $error("special control not written");

  property p_selector;
    mgmt_req_i && !mgmt_we_i && transceiver_select_i == PMD_XCVR_OWN && transceiver_reg_select_i == PMD_REG_ADV |=>
      mgmt_rdata_o[4:0] == 5'h01 && mgmt_rdata_o[15:11] == 5'h00;
  endproperty
  a_selector: assert property (p_selector) else $error("advertise fixed bits wrong");

  property p_alias;
    sw_wr_adv && !mgmt_wr_adv |=> adv_ability_o == $past(sw_wdata_i[4:0]);
  endproperty
  a_alias: assert property (p_alias) else $error("switch write not shared");
endmodule : pmd_regs
`default_nettype wire

/* File: tb/pmd_host_model.sv */
// Purpose: Management host model that reaches the register slice
// Assumes: One access in flight, request pulsed for one cycle
// Notes: Released address and data lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module pmd_host_model
  import pmd_pkg::*;
(
  input wire logic clk_i, // Core clock
  output logic req_o, // Access request
  output logic we_o, // 1 write, 0 read
  output logic [4:0] xcvr_o, // Transceiver address
  output logic [4:0] reg_o, // Register address
  output logic [15:0] wdata_o, // Write data
  input wire logic [15:0] rdata_i, // Read data
  input wire logic ack_i // Access done pulse
);
  int misses = 0;
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    xcvr_o = 5'h00;
    reg_o = 5'h00;
    wdata_o = 16'h0000;
  end
  task automatic acc(input logic we, input logic [4:0] x, input logic [4:0] r, input logic [15:0] wd,
                     output logic [15:0] rd);
    int n;
    @(posedge clk_i);
    req_o <= 1'b1;
    we_o <= we;
    xcvr_o <= x;
    reg_o <= r;
    wdata_o <= wd;
    @(posedge clk_i);
    req_o <= 1'b0;
    xcvr_o <= ~x;
    reg_o <= ~r;
    wdata_o <= ~wd;
    #1;
    n = 0;
    while (ack_i !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 4) misses++;
    rd = rdata_i;
  endtask : acc
  // Reserved low bit always written as zero
  task automatic wr_special(input logic [15:0] v);
    logic [15:0] rd;
    acc(1'b1, PMD_XCVR_OWN, PMD_REG_SPECIAL, {v[15:1], 1'b0}, rd);
  endtask : wr_special
  // Results are trusted only once start reads back clear
  task automatic diag_wait(output logic [15:0] rd);
    int n;
    n = 0;
    do begin
      acc(1'b0, PMD_XCVR_OWN, PMD_REG_DIAG, 16'h0000, rd);
      n++;
    end while (rd[15] !== 1'b0 && n < 8);
  endtask : diag_wait
endmodule : pmd_host_model
`default_nettype wire

/* File: tb/tb_phy_mgmt_ability_diag_regs.sv */
// Purpose: Self-checking bench for the management register slice
// Assumes: Host model on the management side, bench on switch side
// Notes: Random values from a fixed seed mixed with corner cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_phy_mgmt_ability_diag_regs;
  import pmd_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic mgmt_req_i, mgmt_we_i, mgmt_ack_o;
  logic [4:0] transceiver_select_i, transceiver_reg_select_i, adv_ability_o;
  logic [15:0] mgmt_wdata_i, mgmt_rdata_o, rd, wd;
  logic sw_req_i = 1'b0, sw_we_i = 1'b0, polarity_rev_i = 1'b0, crossover_state_i = 1'b0;
  logic [7:0] sw_addr_i = 8'h00, sw_wdata_i = 8'h00, sw_rdata_o, srd, b;
  logic [4:0] partner_ability_i = 5'h00;
  logic diag_done_i = 1'b0, near_short_flag_i = 1'b0;
  logic [1:0] diag_result_i = 2'h0;
  logic [8:0] diag_distance_i = 9'h000;
  logic diag_start_o, force_link_o, pwr_save_dis_o, remote_loop_o;
  logic f_e = 1'b0, p_e = 1'b1, l_e = 1'b0, a9 = 1'b0;
  int fails = 0, checks = 0, cyc = 0;
  pmd_regs dut_u (.clk_i, .reset_n_i, .mgmt_req_i, .mgmt_we_i, .transceiver_select_i, .transceiver_reg_select_i,
    .mgmt_wdata_i, .mgmt_rdata_o, .mgmt_ack_o, .sw_req_i, .sw_we_i, .sw_addr_i, .sw_wdata_i, .sw_rdata_o,
    .partner_ability_i, .polarity_rev_i, .crossover_state_i, .diag_done_i, .diag_result_i, .near_short_flag_i,
    .diag_distance_i, .adv_ability_o, .diag_start_o, .force_link_o, .pwr_save_dis_o, .remote_loop_o);
  pmd_host_model host_u (.clk_i(clk_i), .req_o(mgmt_req_i), .we_o(mgmt_we_i), .xcvr_o(transceiver_select_i),
    .reg_o(transceiver_reg_select_i), .wdata_o(mgmt_wdata_i), .rdata_i(mgmt_rdata_o), .ack_i(mgmt_ack_o));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic sw(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sw_req_i <= 1'b1;
    sw_we_i <= we;
    sw_addr_i <= a;
    sw_wdata_i <= d;
    @(posedge clk_i);
    sw_req_i <= 1'b0;
    sw_addr_i <= ~a;
    sw_wdata_i <= ~d;
    #1;
    srd = sw_rdata_o;
  endtask : sw
  task automatic mw(input logic [4:0] r, input logic [15:0] d);
    host_u.acc(1'b1, PMD_XCVR_OWN, r, d, rd);
  endtask : mw
  task automatic mr(input logic [4:0] r);
    host_u.acc(1'b0, PMD_XCVR_OWN, r, 16'h0000, rd);
  endtask : mr
  function automatic logic [15:0] f_adv(input logic b9, input logic [4:0] ab);
    return {5'h00, ab[4], b9, ab[3:0], PMD_SELECTOR};
  endfunction : f_adv
  function automatic logic [15:0] f_spec();
    return {10'h000, polarity_rev_i, crossover_state_i, f_e, p_e, l_e, 1'b0};
  endfunction : f_spec
  task automatic stop_test();
    fails += host_u.misses;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    void'($urandom(86849));
    mr(PMD_REG_ADV);
    `CHK(rd, f_adv(1'b0, PMD_ADV_RST))
    `CHK(adv_ability_o, PMD_ADV_RST)
    mr(PMD_REG_PARTNER);
    `CHK(rd, 16'h0000)
    mr(PMD_REG_DIAG);
    `CHK(rd, 16'h0000)
    mr(PMD_REG_SPECIAL);
    `CHK(rd, f_spec())
    `CHK({force_link_o, pwr_save_dis_o, remote_loop_o}, 3'b010)
    $display("test reset values done");
    for (int t = 0; t < 32; t++) begin
      if (t == 2) continue;
      host_u.acc(1'b1, 5'(t), PMD_REG_ADV, 16'h0000, rd);
      host_u.acc(1'b0, 5'(t), PMD_REG_ADV, 16'h0000, rd);
      `CHK(rd, 16'h0000)
    end
    `CHK(adv_ability_o, PMD_ADV_RST)
    mr(5'h1e);
    `CHK(rd, 16'h0000)
    $display("test address decode done");
    for (int i = 0; i < 12; i++) begin
      wd = 16'($urandom);
      mw(PMD_REG_ADV, wd);
      a9 = wd[9];
      `CHK(adv_ability_o, {wd[10], wd[8:5]})
      sw(1'b0, PMD_SW_CTRL_ADV, 8'h00);
      `CHK(srd[4:0], {wd[10], wd[8:5]})
      b = 8'($urandom);
      sw(1'b1, PMD_SW_CTRL_ADV, b);
      mr(PMD_REG_ADV);
      `CHK(rd, f_adv(a9, b[4:0]))
      @(posedge clk_i);
      partner_ability_i <= 5'($urandom);
      crossover_state_i <= 1'($urandom);
      polarity_rev_i <= 1'($urandom);
      mr(PMD_REG_PARTNER);
      `CHK(rd, {5'h00, partner_ability_i[4], 1'b0, partner_ability_i[3:0], 5'h00})
      sw(1'b0, PMD_SW_STAT_PARTNER, 8'h00);
      `CHK(srd, {crossover_state_i, 2'b00, partner_ability_i})
      sw(1'b0, PMD_SW_STAT_WIRE, 8'h00);
      `CHK(srd, {2'b00, polarity_rev_i, 5'h00})
      wd = 16'($urandom);
      host_u.wr_special(wd);
      {f_e, p_e, l_e} = wd[3:1];
      `CHK({force_link_o, pwr_save_dis_o, remote_loop_o}, wd[3:1])
      mr(PMD_REG_SPECIAL);
      `CHK(rd, f_spec())
    end
    $display("test random access done");
    for (int k = 0; k < 4; k++) begin
      if (k[0]) begin
        b = {3'($urandom), 1'b1, 3'($urandom), 1'($urandom)};
        sw(1'b1, PMD_SW_CTRL_DIAG, b);
        {f_e, p_e, l_e} = b[3:1];
        `CHK({force_link_o, pwr_save_dis_o, remote_loop_o}, b[3:1])
      end else
        mw(PMD_REG_DIAG, 16'h8000);
      `CHK(diag_start_o, 1'b1)
      mw(PMD_REG_DIAG, 16'h0000);
      mr(PMD_REG_DIAG);
      `CHK(rd[15], 1'b1)
      @(posedge clk_i);
      diag_done_i <= 1'b1;
      diag_result_i <= 2'(k);
      near_short_flag_i <= 1'($urandom);
      diag_distance_i <= 9'($urandom);
      @(posedge clk_i);
      diag_done_i <= 1'b0;
      host_u.diag_wait(rd);
      `CHK(rd, {1'b0, diag_result_i, near_short_flag_i, 3'b000, diag_distance_i})
      `CHK(diag_start_o, 1'b0)
      sw(1'b0, PMD_SW_CTRL_DIAG, 8'h00);
      `CHK(srd, {near_short_flag_i, diag_result_i, 1'b0, f_e, p_e, l_e, diag_distance_i[8]})
      sw(1'b0, PMD_SW_DIST_LOW, 8'h00);
      `CHK(srd, diag_distance_i[7:0])
    end
    $display("test cable diagnostic done");
    stop_test();
  end
endmodule : tb_phy_mgmt_ability_diag_regs
`default_nettype wire
